/* File: logic/apcp_port.sv */
// byte-wide asynchronous peripheral configuration port, device side
//
// Behaviour
// - ready low on receipt, high when buffer frees
// - ready undriven, weak pull-up before clear ends
// - busy two clocks when shifter empty
// - busy up to nine clocks when shifter full
// - last byte shifts seven bits, clock high
// - status drives bus on selects, read, no write
// - status top bit shows ready
// - status lower seven bits always high
// - missing last byte leaves start-up incomplete
// - mode pins 101 select this port
// - shifted config bits mirrored on chain output, none after last byte
// - byte taken on trailing edge of write condition
// - holding buffer plus shift register
`timescale 1ns/10ps
module apcp_port (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // mode and clear pins
  input wire logic mode_select_hi,
  input wire logic mode_select_mid,
  input wire logic mode_select_lo,
  input wire logic config_clear,
  // microprocessor bus
  input wire logic select_active_low,
  input wire logic select_active_high,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  // handshake pin
  output logic ready_out,
  output logic ready_oe_n,
  // last byte marker from start-up control
  input wire logic last_byte,
  // serial outputs
  output logic config_clock,
  output logic config_data,
  output logic config_data_valid,
  output logic chain_out,
  output logic startup_done
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] data_s1_reg;
  logic [7:0] data_s2_reg;
  logic active_mode;
  logic wr_cond;
  logic rd_cond;
  logic wr_cond_d_reg;
  logic wr_fall;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      data_s1_reg <= 8'h00;
      data_s2_reg <= 8'h00;
    end
    else
    begin
      sync1_reg <= {last_byte, config_clear, mode_select_hi, mode_select_mid,
                    mode_select_lo, select_active_high, ~select_active_low,
                    ~write_strobe_n & read_strobe_n};
      sync2_reg <= sync1_reg;
      data_s1_reg <= data_in;
      data_s2_reg <= data_s1_reg;
    end
  end

  // mode pins select this port
  logic sync1_reg_rd;
  logic rd_s1_reg;
  logic rd_s2_reg;

  assign active_mode = (sync2_reg[5:3] == apcp_pkg::MODE_ASYNC_PERIPH);
  assign wr_cond = active_mode && sync2_reg[0] && sync2_reg[1] && sync2_reg[2];
  assign rd_cond = active_mode && sync2_reg[1] && sync2_reg[2] && !sync1_reg_rd;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_s1_reg <= 1'b0;
      rd_s2_reg <= 1'b0;
      wr_cond_d_reg <= 1'b0;
    end
    else
    begin
      rd_s1_reg <= ~read_strobe_n & write_strobe_n;
      rd_s2_reg <= rd_s1_reg;
      wr_cond_d_reg <= wr_cond;
    end
  end

  assign sync1_reg_rd = !rd_s2_reg;
  // byte taken when write condition ends
  assign wr_fall = wr_cond_d_reg && !wr_cond;

  ////////////////////////////////////////////////////////////////////////////
  // holding buffer
  logic hold_valid;
  logic hold_ready;
  logic [7:0] hold_data;
  logic in_ready;
  logic shift_load;

  apcp_buf2 #(
    .WIDTH(apcp_pkg::DATA_W)
  ) u_hold (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(wr_fall),
    .in_ready(in_ready),
    .in_data(data_s2_reg),
    .out_valid(hold_valid),
    .out_ready(hold_ready),
    .out_data(hold_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shift engine: two clk per config clock period
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic shift_full_reg;
  logic last_reg;
  logic phase_reg;
  logic config_clock_reg;
  logic done_reg;
  logic [2:0] top_bit;

  assign top_bit = last_reg ? 3'(apcp_pkg::FINAL_SHIFT_BITS - 1) : 3'h7;
  assign hold_ready = !shift_full_reg && phase_reg && !done_reg;
  assign shift_load = hold_valid && hold_ready;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      phase_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= ~phase_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= apcp_pkg::BIT_CNT_RST;
      shift_full_reg <= 1'b0;
      last_reg <= 1'b0;
      done_reg <= 1'b0;
      config_clock_reg <= 1'b1;
      config_data_valid <= 1'b0;
      chain_out <= 1'b1;
      config_data <= 1'b1;
    end
    else
    begin
      config_data_valid <= 1'b0;
      if (shift_load)
      begin
        shift_reg <= hold_data;
        bit_cnt_reg <= apcp_pkg::BIT_CNT_RST;
        shift_full_reg <= 1'b1;
        last_reg <= sync2_reg[7];
      end
      else if (shift_full_reg && !phase_reg)
      begin
        // falling edge: present next bit lsb first
        config_clock_reg <= 1'b0;
        chain_out <= shift_reg[bit_cnt_reg];
        config_data <= shift_reg[bit_cnt_reg];
      end
      else if (shift_full_reg && phase_reg && !config_clock_reg)
      begin
        config_clock_reg <= 1'b1;
        config_data_valid <= 1'b1;
        if (bit_cnt_reg == top_bit)
        begin
          shift_full_reg <= 1'b0;
          // final byte stops at bit 6, clock left high
          done_reg <= last_reg;
        end
        else
        begin
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
      end
    end
  end

  // start-up completes only after final byte shifted
  logic startup_done_next;
  assign startup_done_next = done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // ready handshake
  logic busy_reg;
  logic init_done_reg;
  logic [2:0] busy_cnt_reg;

  // minimum busy length of two config periods
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busy_cnt_reg <= 3'h0;
    end
    else if (wr_fall)
    begin
      busy_cnt_reg <= 3'(2 * apcp_pkg::BUSY_EMPTY_CYCLES - 1);
    end
    else if (busy_cnt_reg != 3'h0)
    begin
      busy_cnt_reg <= busy_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busy_reg <= 1'b0;
      init_done_reg <= 1'b0;
    end
    else
    begin
      if (sync2_reg[6])
      begin
        init_done_reg <= 1'b1;
      end
      // busy from receipt until holding slot moves to shifter
      if (wr_fall)
      begin
        busy_reg <= 1'b1;
      end
      else if ((busy_cnt_reg == 3'h0) && (shift_load || (!hold_valid && busy_reg)))
      begin
        busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ready_out <= 1'b1;
      ready_oe_n <= 1'b1;
      data_out <= 8'hff;
      data_oe_n <= 1'b1;
      config_clock <= 1'b1;
      startup_done <= 1'b0;
    end
    else
    begin
      ready_out <= !busy_reg && in_ready;
      // pin floats on weak pull-up until clear released
      ready_oe_n <= !(init_done_reg && active_mode);
      data_out <= {!busy_reg && in_ready, 7'h7f};
      data_oe_n <= !rd_cond;
      config_clock <= config_clock_reg;
      startup_done <= startup_done_next;
    end
  end
endmodule : apcp_port

/* File: logic/apcp_pkg.sv */
// constants shared by the async peripheral configuration port
package apcp_pkg;
  localparam int DATA_W = 8;
  localparam logic [2:0] MODE_ASYNC_PERIPH = 3'h5;
  localparam int BUSY_EMPTY_CYCLES = 2;
  localparam int BUSY_MAX_CYCLES = 9;
  localparam int FINAL_SHIFT_BITS = 7;
  localparam int HOLD_READY_CYCLES = 1;
  localparam int NOHANDSHAKE_CYCLES = 10;
  localparam logic [2:0] BIT_CNT_RST = 3'h0;
  localparam logic [7:0] STATUS_LOW_BITS = 8'h7f;
  localparam int CLK_MHZ = 125;
endpackage : apcp_pkg

/* File: logic/apcp_buf2.sv */
// two-entry valid/ready buffer for configuration bytes
`timescale 1ns/10ps
module apcp_buf2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_reg [2];
  logic rd_ptr_reg;
  logic wr_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
      begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      case ({push, pop})
        2'b10: count_reg <= count_reg + 2'h1;
        2'b01: count_reg <= count_reg - 2'h1;
        default: count_reg <= count_reg;
      endcase
    end
  end
endmodule : apcp_buf2

/* File: tb/apcp_host.sv */
// host bus model
`timescale 1ns/10ps
module apcp_host (
  // bus
  input wire logic clk,
  input wire logic ready_pin,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  output logic select_active_low,
  output logic select_active_high,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [7:0] data_in
);
  int n;
  initial
  begin
    {select_active_low, select_active_high, read_strobe_n, write_strobe_n} = 4'hb;
    data_in = 8'h00;
  end
  task automatic pins(input logic [3:0] p, input int w);
    @(negedge clk);
    {select_active_low, select_active_high, read_strobe_n, write_strobe_n} = p;
    n = 0;
    while (n < w)
    begin
      @(negedge clk);
      n = (ready_pin || w > 2) ? n + 1 : 0;
    end
  endtask : pins
  task automatic write(input logic [7:0] b, input bit slow);
    data_in = b;
    pins(4'h6, 2);
    pins(4'hb, 4);
    data_in = ~b;
    n = 0;
    while ((slow || ready_pin) && n < (slow ? 24 : 8))
    begin
      @(negedge clk);
      n++;
    end
  endtask : write
  task automatic status(output logic [7:0] s);
    pins(4'h5, 5);
    s = data_oe_n ? 8'hxx : data_out;
    pins(4'hb, 5);
  endtask : status
endmodule : apcp_host

/* File: tb/apcp_port_chk.sv */
// checker
`timescale 1ns/10ps
module apcp_port_chk (
  // pins
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mode_select_hi,
  input wire logic mode_select_mid,
  input wire logic mode_select_lo,
  input wire logic config_clear,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  input wire logic ready_out,
  input wire logic ready_oe_n,
  input wire logic config_clock,
  input wire logic config_data_valid,
  input wire logic chain_out,
  input wire logic startup_done
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_wr;
    (!write_strobe_n && {mode_select_hi, mode_select_mid, mode_select_lo} == 3'h5)
      ##1 (write_strobe_n && ready_out);
  endsequence
  sequence s_idle;
    config_clock [*6] ##1 $fell(ready_out);
  endsequence
  property p_busy; s_wr |-> ##[3:8] !ready_out; endproperty
  a_busy: assert property (p_busy) else $error("no busy");
  property p_short; s_idle |-> ##[1:5] ready_out; endproperty
  a_short: assert property (p_short) else $error("busy long");
  property p_long; $fell(ready_out) |-> ##[1:20] ready_out; endproperty
  a_long: assert property (p_long) else $error("busy stuck");
  property p_pin; !config_clear [*4] |-> ready_oe_n; endproperty
  a_pin: assert property (p_pin) else $error("pin driven");
  property p_low; !data_oe_n |-> data_out[6:0] == 7'h7f; endproperty
  a_low: assert property (p_low) else $error("status bits");
  property p_rd; $fell(data_oe_n) |-> $past(!read_strobe_n && write_strobe_n, 2); endproperty
  a_rd: assert property (p_rd) else $error("bus driven");
  property p_done; startup_done |-> config_clock && !config_data_valid; endproperty
  a_done: assert property (p_done) else $error("clock moved");
  property p_chain; $changed(chain_out) |-> ##1 $fell(config_clock); endproperty
  a_chain: assert property (p_chain) else $error("chain edge");
  property p_top; !data_oe_n |-> data_out[7] == ready_out; endproperty
  a_top: assert property (p_top) else $error("status ready bit");
endmodule : apcp_port_chk
bind apcp_port apcp_port_chk i_apcp_port_chk (.*);

/* File: tb/apcp_port_test.sv */
// bench
`timescale 1ns/10ps
module apcp_port_test;
  logic clk, sys_rst, config_clear, last_byte, ready_pin, data_oe_n, ready_out, ready_oe_n;
  logic mode_select_hi, mode_select_mid, mode_select_lo, config_clock, config_data;
  logic select_active_low, select_active_high, read_strobe_n, write_strobe_n;
  logic config_data_valid, chain_out, startup_done;
  logic [7:0] data_in, data_out, b;
  int num_errors, compares, seed, cyc, i;
  logic exp_q[$];
  assign ready_pin = ready_oe_n ? 1'h1 : ready_out;  // weak pull-up
  apcp_port i_apcp_port (.*);
  apcp_host i_apcp_host (.*);
  task automatic check(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic send(input logic [7:0] v, input bit slow);
    for (int k = 0; k < (last_byte ? 7 : 8); k++)
      exp_q.push_back(v[k]);  // lsb first
    i_apcp_host.write(v, slow);
  endtask : send
  task automatic idle();
    for (int k = 0; k < 500 && (exp_q.size() || !ready_pin || last_byte && !startup_done); k++)
      @(negedge clk);
  endtask : idle
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      end_of_test();
    end
    if (config_data_valid === 1'h1)
      check("bit", 8'(chain_out), exp_q.size() ? 8'(exp_q.pop_front()) : 8'hxx);
  end
  initial
  begin
    {sys_rst, config_clear, last_byte} = 3'h4;
    {mode_select_hi, mode_select_mid, mode_select_lo} = 3'h5;
    seed = 59178;
    repeat (2) @(negedge clk);
    sys_rst = 1'h0;
    i_apcp_host.status(b);
    check("status", b, 8'hff);
    check("pin off", 8'(ready_oe_n), 8'h01);
    config_clear = 1'h1;
    send(8'ha5, 0);
    check("pin on", 8'(ready_oe_n), 8'h00);
    idle();
    for (i = 0; i < 6; i++)
      send(8'($random(seed)), 0);
    idle();
    for (i = 0; i < 3; i++)
      send(8'($random(seed)), 1);
    idle();
    {mode_select_hi, mode_select_mid, mode_select_lo} = 3'h7;
    i_apcp_host.write(8'h3c, 1);
    {mode_select_hi, mode_select_mid, mode_select_lo} = 3'h5;
    check("early done", 8'(startup_done), 8'h00);
    b = 8'($random(seed));
    last_byte = 1'h1;
    send(b, 1);
    idle();
    check("done", 8'(startup_done), 8'h01);
    check("clock", 8'(config_clock), 8'h01);
    check("last", 8'(chain_out), 8'(b[6]));
    end_of_test();
  end
endmodule : apcp_port_test
